// *** inc/saq_pkg.sv ***
/*
 * Constants, encodings and register map of the selective acquisition qualifier.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package saq_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_BLK1   = 8'h00; // Block 1 setup
	localparam logic [7:0] OFF_BLK2   = 8'h04; // Block 2 setup
	localparam logic [7:0] OFF_CNTCFG = 8'h08; // Counter setup
	localparam logic [7:0] OFF_DELAY  = 8'h0c; // Shared delay and repeat
	localparam logic [7:0] OFF_CTRL   = 8'h10; // Enables and trigger mode
	localparam logic [7:0] OFF_STATUS = 8'h14; // State and error flags
	localparam logic [7:0] OFF_COUNT  = 8'h18; // Counter value
	// ****************************************
	// Block / counter setup field positions
	// ****************************************
	localparam int F_MODE  = 0;  // [1:0] selection or count mode
	localparam int F_OPEN  = 2;  // [3:2] open point
	localparam int F_CLOSE = 4;  // [6:4] close point
	localparam int F_OWORD = 8;  // [10:8] open word index
	localparam int F_CWORD = 12; // [14:12] close word index
	localparam int F_CLKS  = 16; // [19:16] selected clocks
	// ****************************************
	// Delay register fields
	// ****************************************
	localparam int F_DLY    = 0;  // [7:0] samples after word A
	localparam int F_REP    = 8;  // [17:8] repeat count
	localparam int F_ALWAYS = 20; // Always repeat
	// ****************************************
	// Control fields
	// ****************************************
	localparam int F_SEL_EN = 0; // Data selection on
	localparam int F_CNT_EN = 1; // Counter on
	localparam int F_BRK    = 2; // Sequence break trigger mode
	localparam int F_B_W7   = 3; // Word B used as word 7
	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [1:0] M_CLOCKS  = 2'h0; // Only clocks
	localparam logic [1:0] M_WDCLK   = 2'h1; // Words and clocks
	localparam logic [1:0] M_WORDS   = 2'h2; // Only words; counter: words
	localparam logic [1:0] M_ADLY    = 2'h3; // Word A + delay; counter: time
	localparam logic [1:0] O_START   = 2'h0; // Open at acquisition start
	localparam logic [1:0] O_WORD    = 2'h1; // Open on a list word
	localparam logic [1:0] O_WDLY    = 2'h2; // Open on word delay expiry
	localparam logic [2:0] C_END     = 3'h0; // Close at final trigger
	localparam logic [2:0] C_NEXT    = 3'h1; // Close at next sequence event
	localparam logic [2:0] C_WORD    = 3'h2; // Close on a list word
	localparam logic [2:0] C_WDLY    = 3'h3; // Close on word delay expiry
	localparam logic [2:0] C_NEVER   = 3'h4; // Not decoded; default branch closes at final trigger
	localparam logic [1:0] CM_CLOCKS = 2'h0; // Count samples on clocks
	localparam logic [1:0] CM_WDCLK  = 2'h1; // Count words on clocks
	localparam logic [1:0] CM_WORDS  = 2'h2; // Count words on any clock
	localparam logic [1:0] CM_TIME   = 2'h3; // Count elapsed cycles
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000; // Reset of setup words
endpackage

// *** src/saq_top.sv ***
/*
 * Selective acquisition qualifier: two blocks deciding which state samples
 * are written to acquisition memory, plus a windowed counter, behind APB.
 * Assumes samples and sequencer events arrive on the same clock as a
 * one-cycle sample strobe with its clock id and match flags.
 */
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module saq_top #(
	parameter int NCLK = 4, // Clock sources
	parameter int NWRD = 8  // Trigger list words
) (
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            acq_start,
	input  wire logic            acq_end,
	input  wire logic            sample_valid,
	input  wire logic [NCLK-1:0] sample_clk,
	input  wire logic            word_a_match,
	input  wire logic            word_b_match,
	input  wire logic [NWRD-1:0] list_word_hit,
	input  wire logic [NWRD-1:0] list_delay_done,
	output logic                 mem_write,
	output logic                 acq_active,
	output logic                 err_worda_delay_with_break,
	output logic                 err_wordb_with_break,
	output logic                 err_wordb_with_worda_delay
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [31:0] blk1;    // Block 1 setup
		logic [31:0] blk2;    // Block 2 setup
		logic [31:0] cntcfg;  // Counter setup
		logic [31:0] dly;     // Delay and repeat
		logic [3:0]  ctrl;    // Control bits
		logic        active;  // Acquisition running
		logic [1:0]  open;    // Block windows
		logic [1:0]  adly;    // Delay burst running
		logic [7:0]  left1;   // Burst samples left, block 1
		logic [7:0]  left2;   // Burst samples left, block 2
		logic [9:0]  rep1;    // Bursts done, block 1
		logic [9:0]  rep2;    // Bursts done, block 2
		logic        cwin;    // Counter window
		logic [31:0] count;   // Counter value
		logic        done;    // Acquisition finished
		logic [31:0] rdata;   // APB read data
		logic        wr;      // Memory write strobe
	} saq_state_t;
	saq_state_t s_q, s_d;

	// Match terms and sequence event
	logic            wb_ok;   // Word B usable
	logic            wab;     // Word A or B
	logic            seq_evt; // Any sequencer event
	logic            accept1, accept2;
	logic            open_e1, open_e2, close_e1, close_e2, copen, cclose;
	logic            adv;
	logic            sel_c1, sel_c2, sel_cc;

	// Open-point decode, shared by both blocks and counter
	function automatic logic open_hit(input logic [31:0] cfg, input logic st,
		input logic [NWRD-1:0] hit, input logic [NWRD-1:0] dd);
		unique case (cfg[saq_pkg::F_OPEN +: 2])
			saq_pkg::O_START: open_hit = st;
			saq_pkg::O_WORD:  open_hit = hit[cfg[saq_pkg::F_OWORD +: 3]];
			saq_pkg::O_WDLY:  open_hit = dd[cfg[saq_pkg::F_OWORD +: 3]];
			default:          open_hit = 1'b0;
		endcase
	endfunction

	// Close-point decode; END comes from the final trigger
	function automatic logic close_hit(input logic [31:0] cfg, input logic fin,
		input logic nxt, input logic [NWRD-1:0] hit, input logic [NWRD-1:0] dd);
		unique case (cfg[saq_pkg::F_CLOSE +: 3])
			saq_pkg::C_END:  close_hit = fin;
			saq_pkg::C_NEXT: close_hit = nxt;
			saq_pkg::C_WORD: close_hit = hit[cfg[saq_pkg::F_CWORD +: 3]];
			saq_pkg::C_WDLY: close_hit = dd[cfg[saq_pkg::F_CWORD +: 3]];
			default:         close_hit = fin;
		endcase
	endfunction

	// ****************************************
	// Qualification terms
	// ****************************************
	always_comb begin
		wb_ok   = !s_q.ctrl[saq_pkg::F_B_W7];
		wab     = word_a_match || (word_b_match && wb_ok);
		seq_evt = |list_word_hit || |list_delay_done;
		sel_c1  = |(sample_clk & s_q.blk1[saq_pkg::F_CLKS +: NCLK]);
		sel_c2  = |(sample_clk & s_q.blk2[saq_pkg::F_CLKS +: NCLK]);
		sel_cc  = |(sample_clk & s_q.cntcfg[saq_pkg::F_CLKS +: NCLK]);
		// Opening and closing events; the software keeps index order and END legal
		open_e1  = open_hit(s_q.blk1, acq_start, list_word_hit, list_delay_done);
		open_e2  = open_hit(s_q.blk2, acq_start, list_word_hit, list_delay_done);
		close_e1 = close_hit(s_q.blk1, acq_end, seq_evt, list_word_hit,
			list_delay_done);
		close_e2 = close_hit(s_q.blk2, acq_end, seq_evt, list_word_hit,
			list_delay_done);
		copen    = open_hit(s_q.cntcfg, acq_start, list_word_hit, list_delay_done);
		cclose   = close_hit(s_q.cntcfg, acq_end, seq_evt, list_word_hit,
			list_delay_done);
	end

	// Per-block acceptance, one per mode
	function automatic logic blk_take(input logic [1:0] m, input logic ck,
		input logic w, input logic wa, input logic burst);
		unique case (m)
			saq_pkg::M_CLOCKS: blk_take = ck;
			saq_pkg::M_WDCLK:  blk_take = ck && w;
			saq_pkg::M_WORDS:  blk_take = w;
			saq_pkg::M_ADLY:   blk_take = wa || (burst && ck);
		endcase
	endfunction

	always_comb begin
		// Both blocks evaluated in parallel on one sample
		accept1 = sample_valid && s_q.active && s_q.ctrl[saq_pkg::F_SEL_EN] && s_q.open[0] &&
			blk_take(s_q.blk1[1:0], sel_c1, wab, word_a_match, s_q.adly[0]);
		accept2 = sample_valid && s_q.active && s_q.ctrl[saq_pkg::F_SEL_EN] && s_q.open[1] &&
			blk_take(s_q.blk2[1:0], sel_c2, wab, word_a_match, s_q.adly[1]);
		adv = 1'b0;
		// Counter term per count mode
		unique case (s_q.cntcfg[1:0])
			saq_pkg::CM_CLOCKS: adv = sample_valid && sel_cc;
			saq_pkg::CM_WDCLK:  adv = sample_valid && sel_cc && wab;
			saq_pkg::CM_WORDS:  adv = sample_valid && wab;
			saq_pkg::CM_TIME:   adv = 1'b1;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d    = s_q;
		s_d.wr = 1'b0;
		// APB register writes
		if (psel && penable && pwrite) begin
			unique case (paddr)
				saq_pkg::OFF_BLK1:   s_d.blk1   = pwdata;
				saq_pkg::OFF_BLK2:   s_d.blk2   = pwdata;
				saq_pkg::OFF_CNTCFG: s_d.cntcfg = pwdata;
				saq_pkg::OFF_DELAY:  s_d.dly    = pwdata;
				saq_pkg::OFF_CTRL:   s_d.ctrl   = pwdata[3:0];
				default: ;
			endcase
		end
		// Acquisition start clears and opens; end closes all
		if (acq_start) begin
			s_d.active = 1'b1;
			s_d.done   = 1'b0;
			s_d.open   = 2'b00;
			s_d.adly   = 2'b00;
			s_d.rep1   = 10'h000;
			s_d.rep2   = 10'h000;
			s_d.cwin   = 1'b0;
			s_d.count  = 32'h0000_0000;
		end
		if (s_q.active || acq_start) begin
			// Block windows: close then open, so an open event wins
			if (s_q.open[0] && close_e1) s_d.open[0] = 1'b0;
			if (s_q.open[1] && close_e2) s_d.open[1] = 1'b0;
			if (open_e1) s_d.open[0] = 1'b1;
			if (open_e2) s_d.open[1] = 1'b1;
			// Counter window, independent of selection
			if (s_q.cwin && cclose) s_d.cwin = 1'b0;
			if (copen && s_q.ctrl[saq_pkg::F_CNT_EN]) s_d.cwin = 1'b1;
			if (s_q.cwin && adv && !acq_start) s_d.count = s_q.count + 32'h0000_0001;
		end
		// Word A + delay bursts, block 1
		if (accept1 && s_q.blk1[1:0] == saq_pkg::M_ADLY) begin
			if (s_q.adly[0] && !word_a_match) begin
				s_d.left1 = s_q.left1 - 8'h01;
				if (s_q.left1 == 8'h01) s_d.adly[0] = 1'b0;
			end else if (!s_q.adly[0] && (s_q.dly[saq_pkg::F_ALWAYS] ||
					s_q.rep1 < s_q.dly[saq_pkg::F_REP +: 10])) begin
				s_d.adly[0] = s_q.dly[7:0] != 8'h00;
				s_d.left1   = s_q.dly[7:0];
				s_d.rep1    = s_q.rep1 + 10'h001;
			end
		end
		// Word A + delay bursts, block 2
		if (accept2 && s_q.blk2[1:0] == saq_pkg::M_ADLY) begin
			if (s_q.adly[1] && !word_a_match) begin
				s_d.left2 = s_q.left2 - 8'h01;
				if (s_q.left2 == 8'h01) s_d.adly[1] = 1'b0;
			end else if (!s_q.adly[1] && (s_q.dly[saq_pkg::F_ALWAYS] ||
					s_q.rep2 < s_q.dly[saq_pkg::F_REP +: 10])) begin
				s_d.adly[1] = s_q.dly[7:0] != 8'h00;
				s_d.left2   = s_q.dly[7:0];
				s_d.rep2    = s_q.rep2 + 10'h001;
			end
		end
		// Final trigger ends acquisition; counter then holds
		if (acq_end && s_q.active && !acq_start) begin
			s_d.active = 1'b0;
			s_d.done   = 1'b1;
			s_d.open   = 2'b00;
			s_d.cwin   = 1'b0;
		end
		// Write strobe registered, one cycle after the sample
		s_d.wr = accept1 || accept2;
		// Read data captured in setup phase
		s_d.rdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				saq_pkg::OFF_BLK1:   s_d.rdata = s_q.blk1;
				saq_pkg::OFF_BLK2:   s_d.rdata = s_q.blk2;
				saq_pkg::OFF_CNTCFG: s_d.rdata = s_q.cntcfg;
				saq_pkg::OFF_DELAY:  s_d.rdata = s_q.dly;
				saq_pkg::OFF_CTRL:   s_d.rdata = {28'h0000000, s_q.ctrl};
				saq_pkg::OFF_STATUS: s_d.rdata = {24'h000000, err_wordb_with_worda_delay,
					err_wordb_with_break, err_worda_delay_with_break, s_q.cwin,
					s_q.open, s_q.done, s_q.active};
				saq_pkg::OFF_COUNT:  s_d.rdata = s_q.count;
				default:             s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic use_adly, use_b;
	always_comb begin
		use_adly = s_q.ctrl[saq_pkg::F_SEL_EN] &&
			(s_q.blk1[1:0] == saq_pkg::M_ADLY || s_q.blk2[1:0] == saq_pkg::M_ADLY);
		use_b    = s_q.ctrl[saq_pkg::F_SEL_EN] && wb_ok &&
			(s_q.blk1[1:0] == saq_pkg::M_WDCLK || s_q.blk1[1:0] == saq_pkg::M_WORDS ||
			 s_q.blk2[1:0] == saq_pkg::M_WDCLK || s_q.blk2[1:0] == saq_pkg::M_WORDS);
	end
	// Conflict flags; software must keep at most one of three
	assign err_worda_delay_with_break = use_adly && s_q.ctrl[saq_pkg::F_BRK];
	assign err_wordb_with_break       = use_b && s_q.ctrl[saq_pkg::F_BRK];
	assign err_wordb_with_worda_delay = use_b && use_adly;
	assign mem_write  = s_q.wr;
	assign acq_active = s_q.active;
	assign prdata     = s_q.rdata;
	assign pready     = psel && penable; // Zero wait states
	assign pslverr    = 1'b0;

	// ****************************************
	// Checks
	// ****************************************
	// Burst arming: word A taken while idle, delay non-zero, repeats left or always
	sequence burst_arm1_s;
		s_q.blk1[1:0] == saq_pkg::M_ADLY && accept1 && !s_q.adly[0] && word_a_match &&
			s_q.dly[7:0] != 8'h00 && (s_q.dly[saq_pkg::F_ALWAYS] ||
			s_q.rep1 < s_q.dly[saq_pkg::F_REP +: 10]);
	endsequence
	// Last sample of a running burst on block 1
	sequence burst_last1_s;
		s_q.blk1[1:0] == saq_pkg::M_ADLY && accept1 && s_q.adly[0] && !word_a_match &&
			s_q.left1 == 8'h01;
	endsequence
	// Word A seen with the repeat budget spent and no always option
	sequence rep_spent1_s;
		s_q.blk1[1:0] == saq_pkg::M_ADLY && accept1 && !s_q.adly[0] &&
			!s_q.dly[saq_pkg::F_ALWAYS] && s_q.rep1 >= s_q.dly[saq_pkg::F_REP +: 10];
	endsequence
	// A burst must stop after its last counted sample
	burst_end_a: assert property (@(posedge clock) disable iff (rst)
		burst_last1_s |=> !s_q.adly[0]) else $error("burst end");
	// Once the repeats are used up, word A no longer arms a burst
	repeat_limit_a: assert property (@(posedge clock) disable iff (rst)
		rep_spent1_s |=> !s_q.adly[0]) else $error("repeat limit");
	// Time mode adds one per cycle while the window is open
	time_count_a: assert property (@(posedge clock) disable iff (rst)
		s_q.cwin && s_q.active && !acq_start && s_q.cntcfg[1:0] == saq_pkg::CM_TIME
		|=> s_q.count == $past(s_q.count) + 32'h0000_0001) else $error("time count");
	// After acquisition the count stands until the next start
	idle_hold_a: assert property (@(posedge clock) disable iff (rst)
		!s_q.active && !acq_start |=> $stable(s_q.count)) else $error("idle hold");
	write_strobe_a: assert property (@(posedge clock) disable iff (rst)
		(accept1 || accept2) |=> mem_write) else $error("strobe missing");
	no_stray_a: assert property (@(posedge clock) disable iff (rst)
		!(accept1 || accept2) |=> !mem_write) else $error("stray strobe");
	clocks_only_a: assert property (@(posedge clock) disable iff (rst)
		accept1 && s_q.blk1[1:0] == saq_pkg::M_CLOCKS |-> sel_c1) else $error("clock");
	wdclk_a: assert property (@(posedge clock) disable iff (rst)
		accept2 && s_q.blk2[1:0] == saq_pkg::M_WDCLK |-> sel_c2 && wab) else $error("wdclk");
	words_a: assert property (@(posedge clock) disable iff (rst)
		accept1 && s_q.blk1[1:0] == saq_pkg::M_WORDS |-> wab) else $error("words");
	burst_arm_a: assert property (@(posedge clock) disable iff (rst || acq_start)
		burst_arm1_s |=> s_q.adly[0] && s_q.left1 == $past(s_q.dly[7:0])) else $error("burst");
	count_clear_a: assert property (@(posedge clock) disable iff (rst)
		acq_start |=> s_q.count == 32'h0000_0000) else $error("clear");
	count_hold_a: assert property (@(posedge clock) disable iff (rst)
		!s_q.cwin && !acq_start |=> $stable(s_q.count)) else $error("hold");
	final_close_a: assert property (@(posedge clock) disable iff (rst)
		acq_end && s_q.active && !acq_start |=> !s_q.cwin && s_q.open == 2'b00 && s_q.done)
		else $error("end");
	b_w7_a: assert property (@(posedge clock) disable iff (rst)
		s_q.ctrl[saq_pkg::F_B_W7] && !word_a_match |-> !wab) else $error("word b");
endmodule
`default_nettype wire

// *** verif/saq_partner.sv ***
/*
 * Far-side model: probed system and trigger sequencer feeding the qualifier.
 * Assumes one bench process calls beat, after a rising edge at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module saq_partner #(
	parameter int NCLK = 4, // Clock sources
	parameter int NWRD = 8  // Trigger list words
) (
	input  wire logic            clock,
	output logic                 acq_start,
	output logic                 acq_end,
	output logic                 sample_valid,
	output logic      [NCLK-1:0] sample_clk,
	output logic                 word_a_match,
	output logic                 word_b_match,
	output logic      [NWRD-1:0] list_word_hit,
	output logic      [NWRD-1:0] list_delay_done
);
	// ****************************************
	// Idle state at time zero
	// ****************************************
	initial begin
		acq_start       = 1'b0;
		acq_end         = 1'b0;
		sample_valid    = 1'b0;
		sample_clk      = '0;
		word_a_match    = 1'b0;
		word_b_match    = 1'b0;
		list_word_hit   = '0;
		list_delay_done = '0;
	end
	// ****************************************
	// One cycle of sample and sequencer events
	// ****************************************
	// Events are one-cycle pulses; released data lines show the inverse value
	task automatic beat(input logic v, input logic [NCLK-1:0] c, input logic a, b, s, e,
		input logic [NWRD-1:0] h, d);
		@(posedge clock);
		sample_valid    <= v;
		sample_clk      <= c;
		word_a_match    <= a;
		word_b_match    <= b;
		acq_start       <= s;
		acq_end         <= e;
		list_word_hit   <= h;
		list_delay_done <= d;
		@(posedge clock);
		// Stale copies would hide a design that samples without the strobe
		sample_valid    <= 1'b0;
		sample_clk      <= ~c;
		word_a_match    <= ~a;
		word_b_match    <= ~b;
		acq_start       <= 1'b0;
		acq_end         <= 1'b0;
		list_word_hit   <= '0;
		list_delay_done <= '0;
	endtask
endmodule
`default_nettype wire

// *** verif/saq_top_bench.sv ***
/*
 * Self-checking bench of the qualifier: APB setup, samples via the far-side model.
 * Assumes zero-wait APB answers and mem_write one cycle after the sample.
 */
`timescale 1ns/1ps
`default_nettype none
module saq_top_bench;
	// ****************************************
	// Signals and checking state
	// ****************************************
	logic        clock;                     // 25 MHz sampling clock
	logic        rst;                       // Async reset, high
	logic        psel, penable, pwrite;     // APB request
	logic [7:0]  paddr;                     // APB byte address
	logic [31:0] pwdata, prdata, rd, seed;  // Bus data, read copy, random state
	logic        pready, pslverr;           // APB answer
	logic        mem_write, acq_active;     // Design results
	logic [2:0]  err;                       // Conflict flags
	logic        acq_start, acq_end, sample_valid, word_a_match, word_b_match;
	logic [3:0]  sample_clk;                // Clock id of sample
	logic [7:0]  list_word_hit, list_delay_done;
	logic        exp_q[$];                  // Expected store decision per sample
	logic        pend;                      // A sample was offered last cycle
	int          fails, cmp_count;          // Mismatches and comparisons

	saq_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.acq_start(acq_start), .acq_end(acq_end), .sample_valid(sample_valid),
		.sample_clk(sample_clk), .word_a_match(word_a_match), .word_b_match(word_b_match),
		.list_word_hit(list_word_hit), .list_delay_done(list_delay_done),
		.mem_write(mem_write), .acq_active(acq_active),
		.err_worda_delay_with_break(err[0]), .err_wordb_with_break(err[1]),
		.err_wordb_with_worda_delay(err[2]));
	saq_partner ptr (.clock(clock), .acq_start(acq_start), .acq_end(acq_end),
		.sample_valid(sample_valid), .sample_clk(sample_clk), .word_a_match(word_a_match),
		.word_b_match(word_b_match), .list_word_hit(list_word_hit),
		.list_delay_done(list_delay_done));

	// Free-running clock
	always #20 clock = ~clock;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Mismatches %0d, comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One APB transfer; waits for pready under a bound, never a fixed count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) fails++;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, pslverr}, 32'h0);
	endtask
	// Xorshift source for sample clocks and word matches
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Block or counter setup word: mode, open, close, words, clocks
	function automatic logic [31:0] cfg(input logic [1:0] md, op, input logic [2:0] cl, ow, cw,
		input logic [3:0] ck);
		return {12'h0, ck, 1'b0, cw, 1'b0, ow, 1'b0, cl, op, md};
	endfunction
	// Sample with its expected store decision noted first
	task automatic smp(input logic [3:0] c, input logic a, b, e, input logic [7:0] h, d);
		exp_q.push_back(e);
		ptr.beat(1'b1, c, a, b, 1'b0, 1'b0, h, d);
	endtask
	// Sequencer events only; data lines carry junk
	task automatic ev(input logic s, e, input logic [7:0] h, d);
		ptr.beat(1'b0, seed[3:0], seed[4], seed[5], s, e, h, d);
	endtask

	// ****************************************
	// Result watcher
	// ****************************************
	// Judged at the falling edge, when the registered strobe has settled
	always @(negedge clock) begin
		if (pend) begin
			chk({31'h0, mem_write}, {31'h0, exp_q.pop_front()});
		end else if (!rst && mem_write !== 1'b0) begin
			chk({31'h0, mem_write}, 32'h0);
		end
		pend = sample_valid;
	end

	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#400000;
		fails++;
		final_report();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic [3:0]  c;
		logic [1:0]  bm;
		logic        e;
		int          n;
		clock = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 32'ha82e;
		fails = 0;
		cmp_count = 0;
		pend = 1'b0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		// Unmapped place ignores writes and reads zero
		apb(1'b1, 8'h1c, 32'hffff_ffff);
		rdchk(8'h1c, 32'h0);
		rdchk(saq_pkg::OFF_COUNT, 32'h0);
		// Clocks, words-and-clocks and words modes, counter in the matching mode; last pass repeats words with word B as word 7
		for (int m = 0; m < 4; m++) begin
			bm = (m == 3) ? saq_pkg::M_WORDS : m[1:0];
			apb(1'b1, saq_pkg::OFF_CTRL, 32'h3 | ((m == 3) << saq_pkg::F_B_W7));
			apb(1'b1, saq_pkg::OFF_BLK1, cfg(bm, saq_pkg::O_START, saq_pkg::C_END, 3'h0, 3'h0, 4'h2));
			apb(1'b1, saq_pkg::OFF_BLK2, cfg(saq_pkg::M_CLOCKS, saq_pkg::O_WORD, saq_pkg::C_END, 3'h7,
				3'h7, 4'hf));
			apb(1'b1, saq_pkg::OFF_CNTCFG, cfg(bm, saq_pkg::O_START, saq_pkg::C_END, 3'h0, 3'h0, 4'h2));
			ev(1'b1, 1'b0, 8'h00, 8'h00);
			// Registered flag settles after the start edge
			@(negedge clock);
			chk({31'h0, acq_active}, 32'h1);
			rdchk(saq_pkg::OFF_COUNT, 32'h0);
			n = 0;
			repeat (12) begin
				r = xs();
				c = 4'h1 << r[1:0];
				e = (bm == saq_pkg::M_CLOCKS) ? c[1] : (bm == saq_pkg::M_WDCLK) ?
					c[1] & (r[4] | r[5]) : r[4] | (r[5] & (m != 3));
				n += e;
				smp(c, r[4], r[5], e, 8'h00, 8'h00);
			end
			ev(1'b0, 1'b1, 8'h00, 8'h00);
			rdchk(saq_pkg::OFF_COUNT, n);
			smp(4'h2, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
			rdchk(saq_pkg::OFF_COUNT, n);
		end
		// Word A plus delay under break mode: two samples after A, one burst
		apb(1'b1, saq_pkg::OFF_CTRL, 32'h5);
		apb(1'b1, saq_pkg::OFF_DELAY, 32'h0000_0102);
		apb(1'b1, saq_pkg::OFF_BLK1, cfg(saq_pkg::M_ADLY, saq_pkg::O_START, saq_pkg::C_END, 3'h0,
			3'h0, 4'h2));
		ev(1'b1, 1'b0, 8'h00, 8'h00);
		chk({29'h0, err}, 32'h1);
		smp(4'h2, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
		smp(4'h2, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		smp(4'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		smp(4'h2, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		smp(4'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		ev(1'b0, 1'b1, 8'h00, 8'h00);
		// Word windows: block 1 word 3 to 5, block 2 word 6 to next, counter word 3 to delay 5
		apb(1'b1, saq_pkg::OFF_CTRL, 32'h3);
		apb(1'b1, saq_pkg::OFF_BLK1, cfg(saq_pkg::M_CLOCKS, saq_pkg::O_WORD, saq_pkg::C_WORD, 3'h3,
			3'h5, 4'hf));
		apb(1'b1, saq_pkg::OFF_BLK2, cfg(saq_pkg::M_CLOCKS, saq_pkg::O_WORD, saq_pkg::C_NEXT, 3'h6,
			3'h0, 4'hf));
		apb(1'b1, saq_pkg::OFF_CNTCFG, cfg(saq_pkg::CM_CLOCKS, saq_pkg::O_WORD, saq_pkg::C_WDLY,
			3'h3, 3'h5, 4'hf));
		ev(1'b1, 1'b0, 8'h00, 8'h00);
		smp(4'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		ev(1'b0, 1'b0, 8'h08, 8'h00);
		smp(4'h4, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		smp(4'h1, 1'b0, 1'b0, 1'b1, 8'h20, 8'h00);
		smp(4'h8, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		ev(1'b0, 1'b0, 8'h40, 8'h00);
		smp(4'h2, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		ev(1'b0, 1'b0, 8'h00, 8'h40);
		smp(4'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		ev(1'b0, 1'b0, 8'h00, 8'h20);
		smp(4'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		ev(1'b0, 1'b1, 8'h00, 8'h00);
		rdchk(saq_pkg::OFF_COUNT, 32'd5);
		// Time mode: start edge to end edge, twelve counted edges
		apb(1'b1, saq_pkg::OFF_CNTCFG, cfg(saq_pkg::CM_TIME, saq_pkg::O_START, saq_pkg::C_END,
			3'h0, 3'h0, 4'h0));
		ev(1'b1, 1'b0, 8'h00, 8'h00);
		repeat (10) @(posedge clock);
		ev(1'b0, 1'b1, 8'h00, 8'h00);
		rdchk(saq_pkg::OFF_COUNT, 32'd12);
		repeat (3) @(posedge clock);
		final_report();
	end
endmodule
`default_nettype wire
